// >>> verilog/qsp_consts.svh
// constants of the quad rate sram port interface
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH

// default data width of one burst word (36-bit configuration)
`define QSP_DATA_W_DEF 36
// default address width matching the 36-bit configuration
`define QSP_ADDR_W_DEF 17
// address widths per configuration
`define QSP_ADDR_W_X8 19
`define QSP_ADDR_W_X18 18
`define QSP_ADDR_W_X36 17
// words per burst and width of the beat counter
`define QSP_BURST_LEN 4
`define QSP_BEAT_W 2
// lane widths for nibble and byte masks
`define QSP_NIBBLE_W 4
`define QSP_BYTE_W 9
// data width that selects nibble masking
`define QSP_NIBBLE_CFG_W 8
// synchroniser depth in flip-flops
`define QSP_SYNC_STAGES 2
// last beat index of a burst
`define QSP_LAST_BEAT 2'h3
// beat index at which a positive output edge drives the third word
`define QSP_MID_BEAT 2'h1

`endif

// >>> verilog/qsp_pkg.sv
// types shared by the quad rate sram port interface
package qsp_pkg;

    // read side sequencing, gray coded along idle -> burst -> tail
    typedef enum logic [1:0] {
        QSP_RD_IDLE  = 2'h0,
        QSP_RD_BURST = 2'h1,
        QSP_RD_TAIL  = 2'h3
    } qsp_rd_state_t;

endpackage

// >>> verilog/qsp_sync.sv
// two flip-flop synchroniser with rising edge detect per bit
`timescale 1ns/1ps
`default_nettype none

module qsp_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out,
    output logic [W-1:0] rise_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] prev;
    } qsp_sync_st_t;

    qsp_sync_st_t st_q;
    qsp_sync_st_t st_d;

    // -----------------------------------------------------------------
    // next state: meta feeds stable only
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
        st_d.prev = st_q.stable;
    end

    // state register, cleared by reset even with ce low, else frozen while ce is low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

    // rising edge detect per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise_out[i] = st_q.stable[i] & ~st_q.prev[i];
        end
    endgenerate

endmodule

`default_nettype wire

// >>> verilog/qsp_top.sv
// device side of the quad rate sram port interface with its memory array
//
// What this block does
// - Write select low at K rise starts write
// - Eight-bit: two nibble masks, [3:0] and [7:4]
// - Deasserted nibble mask keeps stored nibble unchanged
// - Byte masks cover nine bits each, ascending
// - Deasserted byte mask keeps stored byte unchanged
// - Shared address bus sampled on K rise
// - Address width 19/18/17; four-word burst location
// - Address ignored while port select deasserted
// - Read select low at K rise starts read
// - Reads return four sequential words; a read select while a read is still pending is dropped
// - Deselect: finish burst, float after C rise, or after K rise in single clock mode
// - Output on C and C_n, or K pair
// - Accesses start only on K rising edge
// - K_n rising edge also captures data, masks
// - Controller holds write data for both edges
// - Free running echo clocks follow output clocks
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_top #(
    parameter int DATA_W = `QSP_DATA_W_DEF,
    parameter int ADDR_W = `QSP_ADDR_W_DEF,
    // mask lanes: two nibbles at eight bits, else one per nine bits
    parameter int MASK_W = (DATA_W == `QSP_NIBBLE_CFG_W) ? 2 : DATA_W / `QSP_BYTE_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [MASK_W-1:0] byte_write_mask_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_out_oe,
    output logic echo_clock,
    output logic echo_clock_n
);

    localparam int LANE_W = (DATA_W == `QSP_NIBBLE_CFG_W) ? `QSP_NIBBLE_W : `QSP_BYTE_W;
    localparam int BW = `QSP_BEAT_W;
    localparam int DEPTH = `QSP_BURST_LEN << ADDR_W;
    localparam int SW = 7 + ADDR_W + DATA_W + MASK_W;

    // -----------------------------------------------------------------
    // input synchronisation
    // -----------------------------------------------------------------
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_sync;
    logic [SW-1:0] pins_rise;

    assign pins_raw = {byte_write_mask_n, data_in, addr, single_clock_mode, read_port_select_n,
                       write_port_select_n, c_clk_n, c_clk, k_clk_n, k_clk};

    qsp_sync #(
        .W(SW)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .async_in(pins_raw),
        .sync_out(pins_sync),
        .rise_out(pins_rise)
    );

    logic k_s;
    logic kn_s;
    logic c_s;
    logic cn_s;
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic wps_n_s;
    logic rps_n_s;
    logic single_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] din_s;
    logic [MASK_W-1:0] mask_n_s;

    assign {k_s, kn_s, c_s, cn_s} = {pins_sync[0], pins_sync[1], pins_sync[2], pins_sync[3]};
    assign {k_rise, kn_rise, c_rise, cn_rise} = {pins_rise[0], pins_rise[1], pins_rise[2], pins_rise[3]};
    assign wps_n_s = pins_sync[4];
    assign rps_n_s = pins_sync[5];
    assign single_s = pins_sync[6];
    assign addr_s = pins_sync[7 +: ADDR_W];
    assign din_s = pins_sync[7 + ADDR_W +: DATA_W];
    assign mask_n_s = pins_sync[7 + ADDR_W + DATA_W +: MASK_W];

    // output clock edges: C pair, or K pair in single clock mode
    logic out_pos_rise;
    logic out_neg_rise;
    assign out_pos_rise = single_s ? k_rise : c_rise;
    assign out_neg_rise = single_s ? kn_rise : cn_rise;

    // -----------------------------------------------------------------
    // memory array and lane masking
    // -----------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] lane_bits;

    // one bit pattern per mask lane, deasserted lanes stay out
    genvar l;
    generate
        for (l = 0; l < MASK_W; l++) begin : g_lane
            assign lane_bits[l*LANE_W +: LANE_W] = {LANE_W{~mask_n_s[l]}};
        end
        if (MASK_W * LANE_W < DATA_W) begin : g_pad
            assign lane_bits[DATA_W-1:MASK_W*LANE_W] = '0;
        end
    endgenerate

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic wr_busy;
        logic [BW-1:0] wr_beat;
        logic [ADDR_W-1:0] wr_addr;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_pend_addr;
        qsp_pkg::qsp_rd_state_t rd_state;
        logic [BW-1:0] rd_beat;
        logic [ADDR_W-1:0] rd_addr;
        logic [DATA_W-1:0] dout;
        logic dout_oe;
        logic echo;
        logic echo_n;
    } qsp_st_t;

    qsp_st_t st_q;
    qsp_st_t st_d;
    logic wr_en;
    logic [ADDR_W+BW-1:0] wr_idx;
    logic [ADDR_W+BW-1:0] rd_idx;
    logic [BW-1:0] rd_next_beat;
    logic wr_last;

    // -----------------------------------------------------------------
    // write sequencing
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        wr_en = 1'b0;
        wr_last = 1'b0;
        wr_idx = {st_q.wr_addr, st_q.wr_beat};
        rd_idx = '0;
        rd_next_beat = st_q.rd_beat + 2'h1;
        // beats alternate K_n rise then K rise after the select edge
        if (st_q.wr_busy && (k_rise || kn_rise)) begin
            wr_en = 1'b1;
            st_d.wr_beat = st_q.wr_beat + 2'h1;
            if (st_q.wr_beat == `QSP_LAST_BEAT) begin
                st_d.wr_busy = 1'b0;
                wr_last = 1'b1;
            end
        end
        // new write only on K rise, address taken only when selected
        if (k_rise && !wps_n_s && (!st_q.wr_busy || wr_last)) begin
            st_d.wr_busy = 1'b1;
            st_d.wr_beat = '0;
            st_d.wr_addr = addr_s;
        end

        // -------------------------------------------------------------
        // read sequencing: pos edge words 0,2, neg edge words 1,3
        // -------------------------------------------------------------
        if (out_pos_rise) begin
            if (st_q.rd_state == qsp_pkg::QSP_RD_BURST && st_q.rd_beat == `QSP_MID_BEAT) begin
                st_d.rd_beat = rd_next_beat;
                rd_idx = {st_q.rd_addr, rd_next_beat};
                st_d.dout = mem[rd_idx];
            end else if (st_q.rd_pend && st_q.rd_state != qsp_pkg::QSP_RD_BURST) begin
                st_d.rd_pend = 1'b0;
                st_d.rd_state = qsp_pkg::QSP_RD_BURST;
                st_d.rd_beat = '0;
                st_d.rd_addr = st_q.rd_pend_addr;
                rd_idx = {st_q.rd_pend_addr, 2'h0};
                st_d.dout = mem[rd_idx];
                st_d.dout_oe = 1'b1;
            end else if (st_q.rd_state == qsp_pkg::QSP_RD_TAIL) begin
                st_d.rd_state = qsp_pkg::QSP_RD_IDLE;
                st_d.dout_oe = 1'b0;
                st_d.dout = '0;
            end
        end else if (out_neg_rise && st_q.rd_state == qsp_pkg::QSP_RD_BURST) begin
            st_d.rd_beat = rd_next_beat;
            rd_idx = {st_q.rd_addr, rd_next_beat};
            st_d.dout = mem[rd_idx];
            if (rd_next_beat == `QSP_LAST_BEAT) begin
                st_d.rd_state = qsp_pkg::QSP_RD_TAIL;
            end
        end
        // read request on K rise; set wins over the consume above
        if (k_rise && !rps_n_s && !(st_q.rd_pend && st_d.rd_pend)) begin
            st_d.rd_pend = 1'b1;
            st_d.rd_pend_addr = addr_s;
        end

        // echo clocks follow the active output clock pair
        st_d.echo = single_s ? k_s : c_s;
        st_d.echo_n = single_s ? kn_s : cn_s;
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // masked write, unselected lanes keep their stored bits
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_idx] <= (mem[wr_idx] & ~lane_bits) | (din_s & lane_bits);
        end
    end

    assign data_out = st_q.dout;
    assign data_out_oe = st_q.dout_oe;
    assign echo_clock = st_q.echo;
    assign echo_clock_n = st_q.echo_n;

endmodule

`default_nettype wire

// >>> verification/qsp_ctrl_model.sv
// controller model: clock pairs, write and read requests
`timescale 1ns/1ps
`default_nettype none
module qsp_ctrl_model (
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic wps_n,
    output logic rps_n,
    output logic [5:0] addr,
    output logic [35:0] din,
    output logic [3:0] mask_n
);
    // idle levels at time zero
    initial begin
        k_clk = 0;
        k_clk_n = 1;
        wps_n = 1;
        rps_n = 1;
        addr = 0;
        din = 0;
        mask_n = 0;
    end
    // free running pairs, output pair trails by 10 ns
    always #100 begin
        k_clk = ~k_clk;
        k_clk_n = ~k_clk;
        c_clk <= #10 k_clk;
        c_clk_n <= #10 k_clk_n;
    end
    // select then four words on alternate edges, bus inverted after
    task automatic write_burst(input logic [5:0] a, input logic [35:0] d, input logic [3:0] m, input logic s);
        @(posedge k_clk_n) #27;
        wps_n = s;
        addr = a;
        for (int n = 0; n < 4; n++) begin
            if (n[0]) @(posedge k_clk_n);
            else @(posedge k_clk);
            #27;
            wps_n = 1'b1;
            addr = ~a;
            din = d ^ 36'(n);
            mask_n = m;
        end
        @(posedge k_clk) #27;
        din = ~din;
        mask_n = ~mask_n;
    endtask
    // one read select across one positive input edge
    task automatic read_req(input logic [5:0] a);
        @(posedge k_clk_n) #27;
        rps_n = 1'b0;
        addr = a;
        @(posedge k_clk) #27;
        rps_n = 1'b1;
        addr = ~a;
    endtask
    // read select low across a negative input edge only
    task automatic read_on_neg(input logic [5:0] a);
        @(posedge k_clk) #27;
        rps_n = 1'b0;
        addr = a;
        @(posedge k_clk_n) #27;
        rps_n = 1'b1;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

// >>> verification/qsp_top_sva.sv
// pin assertions of the sram port interface
`timescale 1ns/1ps
`default_nettype none
module qsp_top_sva #(
    parameter int DATA_W = 36
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic k_clk,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    input wire logic read_port_select_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_out_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    logic [7:0] run_q;
    logic [7:0] idle_q;
    // cycles spent driving, cycles since read select low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_q <= 8'h00;
            idle_q <= 8'hFF;
        end else begin
            run_q <= data_out_oe ? run_q + 8'h01 : 8'h00;
            idle_q <= !read_port_select_n ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    quiet_after_reset_a: assert property ($rose(nrst) |-> !data_out_oe [*3])
        else $error("output enabled right after reset");
    idle_zero_out_a: assert property (!data_out_oe |-> data_out == '0)
        else $error("data driven while disabled");
    echo_pos_a: assert property ($rose(c_clk) && !single_clock_mode |-> ##[2:5] echo_clock)
        else $error("echo missed output clock");
    echo_neg_a: assert property ($rose(c_clk_n) && !single_clock_mode |-> ##[2:5] echo_clock_n)
        else $error("echo missed negative clock");
    echo_single_a: assert property ($rose(k_clk) && single_clock_mode |-> ##[2:5] echo_clock)
        else $error("echo missed input clock");
    burst_len_a: assert property ($fell(data_out_oe) |-> run_q[3:0] == 4'h0 && run_q != 8'h00)
        else $error("burst not four words long");
    word_step_a: assert property (data_out_oe && $past(data_out_oe) && $changed(data_out) |-> run_q[1:0] == 2'h0)
        else $error("word changed off a clock edge");
    read_cause_a: assert property ($rose(data_out_oe) |-> idle_q < 8'h28)
        else $error("read without select");
endmodule
bind qsp_top qsp_top_sva #(.DATA_W(DATA_W)) sva_u (.clk(clk), .nrst(nrst), .k_clk(k_clk), .c_clk(c_clk),
    .c_clk_n(c_clk_n), .single_clock_mode(single_clock_mode), .read_port_select_n(read_port_select_n),
    .data_out(data_out), .data_out_oe(data_out_oe), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n));
`default_nettype wire

// >>> verification/qsp_top_bench.sv
// bench of the sram port interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, s); end end
module qsp_top_bench;
    typedef struct packed {logic [5:0] a; logic [35:0] d; logic [3:0] m;} qsp_row_t;
    logic clk, nrst, mode, k, kn, c, cn, wps_n, rps_n, oe, eck, eckn;
    logic [5:0] addr;
    logic [35:0] din, dout;
    logic [7:0] dout8;
    logic [3:0] mask_n;
    int mismatches = 0;
    int n_tests = 0;
    qsp_row_t rows [4] = '{'{6'h00, 36'h123456789, 4'h0}, '{6'h3F, 36'hF0F0F0F0F, 4'hF},
        '{6'h15, 36'hA5A5A5A5A, 4'h5}, '{6'h2A, 36'h0FEDCBA98, 4'hA}};
    qsp_ctrl_model ctrl_u (.k_clk(k), .k_clk_n(kn), .c_clk(c), .c_clk_n(cn), .wps_n(wps_n), .rps_n(rps_n),
        .addr(addr), .din(din), .mask_n(mask_n));
    qsp_top #(.DATA_W(36), .ADDR_W(6)) dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .k_clk(k), .k_clk_n(kn),
        .c_clk(c), .c_clk_n(cn), .single_clock_mode(mode), .write_port_select_n(wps_n),
        .read_port_select_n(rps_n), .addr(addr), .data_in(din), .byte_write_mask_n(mask_n),
        .data_out(dout), .data_out_oe(oe), .echo_clock(eck), .echo_clock_n(eckn));
    // eight-bit configuration on the same pins, low two mask lanes act as nibble masks
    qsp_top #(.DATA_W(8), .ADDR_W(6)) dut8_u (.clk(clk), .nrst(nrst), .ce(1'b1), .k_clk(k), .k_clk_n(kn),
        .c_clk(c), .c_clk_n(cn), .single_clock_mode(mode), .write_port_select_n(wps_n),
        .read_port_select_n(rps_n), .addr(addr), .data_in(din[7:0]), .byte_write_mask_n(mask_n[1:0]),
        .data_out(dout8), .data_out_oe(), .echo_clock(), .echo_clock_n());
    always #12.5 clk = ~clk;
    // verdict and end of run
    task automatic stop_test;
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // read a burst, masked lanes hold the first write
    task automatic check_read(input logic [5:0] a, input logic [35:0] d, input logic [3:0] m);
        logic [35:0] lm;
        logic [7:0] ln;
        int i;
        lm = '0;
        ln = '0;
        for (i = 0; i < 4; i++) if (!m[i]) lm[i*9 +: 9] = 9'h1FF;
        for (i = 0; i < 2; i++) if (!m[i]) ln[i*4 +: 4] = 4'hF;
        ctrl_u.read_req(a);
        i = 0;
        while (oe !== 1'b1 && i < 40) begin @(posedge clk); #1; i++; end
        `CHK("oe", 1'b1, oe)
        repeat (2) @(posedge clk);
        for (i = 0; i < 4; i++) begin
            #1 `CHK("word", d ^ 36'(i) ^ lm, dout)
            `CHK("word8", 8'(d ^ 36'(i)) ^ ln, dout8)
            repeat (4) @(posedge clk);
        end
        #1 `CHK("oe off", 1'b0, oe)
    endtask
    // watchdog
    initial begin
        #200000;
        mismatches++;
        stop_test;
    end
    // reset, table rows, then awkward cases
    initial begin
        clk = 0;
        nrst = 0;
        mode = 0;
        repeat (12) @(posedge clk);
        #2 `CHK("oe rst", 1'b0, oe)
        nrst = 1;
        foreach (rows[r]) begin
            ctrl_u.write_burst(rows[r].a, rows[r].d, 4'h0, 1'b0);
            ctrl_u.write_burst(rows[r].a, ~rows[r].d, rows[r].m, 1'b0);
            check_read(rows[r].a, rows[r].d, rows[r].m);
        end
        ctrl_u.write_burst(rows[0].a, 36'h0, 4'h0, 1'b1);
        check_read(rows[0].a, rows[0].d, rows[0].m);
        ctrl_u.read_on_neg(rows[1].a);
        repeat (12) @(posedge clk);
        #1 `CHK("neg only", 1'b0, oe)
        @(posedge clk) #2 mode = 1'b1;
        repeat (8) @(posedge clk);
        check_read(rows[2].a, rows[2].d, rows[2].m);
        @(posedge clk) #2 nrst = 0;
        repeat (4) @(posedge clk);
        #2 nrst = 1;
        check_read(rows[3].a, rows[3].d, rows[3].m);
        stop_test;
    end
endmodule
`default_nettype wire
